//--- uss_pkg.sv
// shared constants and carrier types of the synchronous slave serial port
package uss_pkg;

  // register address: bank in the upper two bits, offset in the lower five
  localparam int unsigned ADDR_W = 7;

  localparam logic [ADDR_W-1:0] ADDR_RX_STATUS_CONTROL      = 7'h13;
  localparam logic [ADDR_W-1:0] ADDR_RX_DATA_BUFFER         = 7'h14;
  localparam logic [ADDR_W-1:0] ADDR_TX_STATUS_CONTROL      = 7'h15;
  localparam logic [ADDR_W-1:0] ADDR_TX_DATA_BUFFER         = 7'h16;
  localparam logic [ADDR_W-1:0] ADDR_BAUD_RATE_DIVISOR      = 7'h17;
  localparam logic [ADDR_W-1:0] ADDR_CORE_CONTROL           = 7'h18;
  localparam logic [ADDR_W-1:0] ADDR_PERIPHERAL_IRQ_FLAGS   = 7'h36;
  localparam logic [ADDR_W-1:0] ADDR_PERIPHERAL_IRQ_ENABLES = 7'h37;

  // rx_status_control fields
  localparam int unsigned RX_SERIAL_PORT_ENABLE       = 7;
  localparam int unsigned RX_NINE_BIT_RX_SELECT       = 6;
  localparam int unsigned RX_SINGLE_RECEIVE_ENABLE    = 5;
  localparam int unsigned RX_CONTINUOUS_RECEIVE_EN    = 4;
  localparam int unsigned RX_FRAMING_ERROR            = 2;
  localparam int unsigned RX_OVERRUN_ERROR            = 1;
  localparam int unsigned RX_NINTH_BIT                = 0;

  // tx_status_control fields
  localparam int unsigned TX_CLOCK_SOURCE_SELECT      = 7;
  localparam int unsigned TX_NINE_BIT_TX_SELECT       = 6;
  localparam int unsigned TX_TRANSMIT_ENABLE          = 5;
  localparam int unsigned TX_SYNC_MODE                = 4;
  localparam int unsigned TX_SHIFT_EMPTY              = 1;
  localparam int unsigned TX_NINTH_BIT                = 0;

  // peripheral irq flag / enable fields
  localparam int unsigned IRQ_TRANSMIT                = 1;
  localparam int unsigned IRQ_RECEIVE                 = 0;

  // core_control fields
  localparam int unsigned CORE_GLOBAL_IRQ_DISABLE     = 0;

  // reset values
  localparam logic [7:0] RST_RX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] RST_TX_CONTROL        = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS         = 8'h02;
  localparam logic [7:0] RST_IRQ_ENABLES       = 8'h00;
  localparam logic       RST_GLOBAL_IRQ_DIS    = 1'b1;

  // word lengths and the shared peripheral vector
  localparam logic [3:0]  BITS_8         = 4'h8;
  localparam logic [3:0]  BITS_9         = 4'h9;
  localparam logic [15:0] VEC_PERIPHERAL = 16'h0020;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } uss_bus_req_s;

  typedef struct packed {
    logic data_out;
    logic data_oe;
  } uss_link_out_s;

endpackage : uss_pkg

//--- uss_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module uss_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : uss_sync

`default_nettype wire

//--- uss_core.sv
// synchronous slave serial port: registers, shifters, flags and interrupt
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module uss_core
  import uss_pkg::*;
(
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          arst_n,
  // register port
  input  wire uss_bus_req_s  bus_req,
  output var  logic [7:0]    rd_data,
  // serial link pins
  input  wire logic          shift_clk_pin,
  input  wire logic          data_pin_in,
  output var  uss_link_out_s link_out,
  // interrupt and wake
  output var  logic          irq,
  output var  logic          wake,
  output var  logic [15:0]   irq_vector
);

  // -------- pin synchronisers --------
  logic [1:0] pins_s;
  logic       ck_s;
  logic       dt_s;
  logic       ck_d_r;
  logic       ck_fall;

  uss_sync #(.WIDTH(2)) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in ({shift_clk_pin, data_pin_in}),
    .sync_out (pins_s)
  );

  assign ck_s = pins_s[1];
  assign dt_s = pins_s[0];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ck_d_r <= 1'b0;
    end else begin
      ck_d_r <= ck_s;
    end
  end

  // both directions move on the falling edge of the master's clock
  assign ck_fall = ck_d_r & ~ck_s;

  // -------- register state --------
  logic       serial_port_enable_r;
  logic       rx9_r;
  logic       single_receive_enable_r;
  logic       continuous_receive_enable_r;
  logic       overrun_error_r;
  logic       rx_ninth_bit_r;
  logic       clock_source_select_r;
  logic       tx9_r;
  logic       transmit_enable_r;
  logic       sync_r;
  logic       tx_ninth_bit_r;
  logic [7:0] baud_rate_divisor_r;
  logic [7:0] rx_data_buffer_r;
  logic       transmit_flag_r;
  logic       receive_flag_r;
  logic       transmit_irq_enable_r;
  logic       receive_irq_enable_r;
  logic       global_irq_disable_r;

  logic wr_rx_status_control;
  logic wr_tx_status_control;
  logic wr_tx_data_buffer;
  logic wr_pie;
  logic wr_core;
  logic wr_baud_rate_divisor;
  logic rd_rx_data_buffer;
  logic rd_pir;

  function automatic logic hit(input logic          strobe,
                               input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] target);
    hit = strobe & (a == target);
  endfunction : hit

  assign wr_rx_status_control = hit(bus_req.wr, bus_req.addr, ADDR_RX_STATUS_CONTROL);
  assign wr_tx_status_control = hit(bus_req.wr, bus_req.addr, ADDR_TX_STATUS_CONTROL);
  assign wr_tx_data_buffer = hit(bus_req.wr, bus_req.addr, ADDR_TX_DATA_BUFFER);
  assign wr_baud_rate_divisor = hit(bus_req.wr, bus_req.addr, ADDR_BAUD_RATE_DIVISOR);
  assign wr_pie   = hit(bus_req.wr, bus_req.addr, ADDR_PERIPHERAL_IRQ_ENABLES);
  assign wr_core  = hit(bus_req.wr, bus_req.addr, ADDR_CORE_CONTROL);
  assign rd_rx_data_buffer = hit(bus_req.rd, bus_req.addr, ADDR_RX_DATA_BUFFER);
  assign rd_pir   = hit(bus_req.rd, bus_req.addr, ADDR_PERIPHERAL_IRQ_FLAGS);

  // slave mode only: sync set and clock source clear
  logic slave_on;
  logic tx_on;
  logic rx_on;

  assign slave_on = serial_port_enable_r & sync_r & ~clock_source_select_r;
  // the data pin is shared, so an active receive owns it
  assign tx_on    = slave_on & transmit_enable_r & ~continuous_receive_enable_r;
  // single receive enable deliberately plays no part here
  assign rx_on    = slave_on & continuous_receive_enable_r;

  // -------- control registers --------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_port_enable_r <= RST_RX_STATUS_CONTROL[RX_SERIAL_PORT_ENABLE];
      rx9_r  <= RST_RX_STATUS_CONTROL[RX_NINE_BIT_RX_SELECT];
      single_receive_enable_r <= RST_RX_STATUS_CONTROL[RX_SINGLE_RECEIVE_ENABLE];
      continuous_receive_enable_r <= RST_RX_STATUS_CONTROL[RX_CONTINUOUS_RECEIVE_EN];
    end else if (wr_rx_status_control) begin
      serial_port_enable_r <= bus_req.wdata[RX_SERIAL_PORT_ENABLE];
      rx9_r  <= bus_req.wdata[RX_NINE_BIT_RX_SELECT];
      single_receive_enable_r <= bus_req.wdata[RX_SINGLE_RECEIVE_ENABLE];
      continuous_receive_enable_r <= bus_req.wdata[RX_CONTINUOUS_RECEIVE_EN];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      clock_source_select_r <= RST_TX_CONTROL[TX_CLOCK_SOURCE_SELECT];
      tx9_r  <= RST_TX_CONTROL[TX_NINE_BIT_TX_SELECT];
      transmit_enable_r <= RST_TX_CONTROL[TX_TRANSMIT_ENABLE];
      sync_r <= RST_TX_CONTROL[TX_SYNC_MODE];
      tx_ninth_bit_r <= RST_TX_CONTROL[TX_NINTH_BIT];
    end else if (wr_tx_status_control) begin
      clock_source_select_r <= bus_req.wdata[TX_CLOCK_SOURCE_SELECT];
      tx9_r  <= bus_req.wdata[TX_NINE_BIT_TX_SELECT];
      transmit_enable_r <= bus_req.wdata[TX_TRANSMIT_ENABLE];
      sync_r <= bus_req.wdata[TX_SYNC_MODE];
      tx_ninth_bit_r <= bus_req.wdata[TX_NINTH_BIT];
    end
  end

  // divisor is stored only; the slave never generates a clock
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_rate_divisor_r <= 8'h00;
    end else if (wr_baud_rate_divisor) begin
      baud_rate_divisor_r <= bus_req.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      transmit_irq_enable_r <= RST_IRQ_ENABLES[IRQ_TRANSMIT];
      receive_irq_enable_r <= RST_IRQ_ENABLES[IRQ_RECEIVE];
    end else if (wr_pie) begin
      transmit_irq_enable_r <= bus_req.wdata[IRQ_TRANSMIT];
      receive_irq_enable_r <= bus_req.wdata[IRQ_RECEIVE];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      global_irq_disable_r <= RST_GLOBAL_IRQ_DIS;
    end else if (wr_core) begin
      global_irq_disable_r <= bus_req.wdata[CORE_GLOBAL_IRQ_DISABLE];
    end
  end

  // -------- transmit path --------
  logic [7:0] txbuf_r;
  logic       txbuf_full_r;
  logic [8:0] tsr_r;
  logic [3:0] tx_cnt_r;
  logic       tx_busy_r;
  logic       tx_load;

  // a full buffer moves over as soon as the shifter is free
  assign tx_load = tx_on & ~tx_busy_r & txbuf_full_r;

  // a write to a still-full buffer is dropped, the held word wins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txbuf_r      <= 8'h00;
      txbuf_full_r <= 1'b0;
    end else if (tx_load) begin
      txbuf_full_r <= 1'b0;
    end else if (wr_tx_data_buffer && !txbuf_full_r) begin
      txbuf_r      <= bus_req.wdata;
      txbuf_full_r <= 1'b1;
    end
  end

  // shifting is clocked by core_clk and steps on each synchronised fall of the pin clock
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tsr_r     <= 9'h000;
      tx_cnt_r  <= 4'h0;
      tx_busy_r <= 1'b0;
    end else if (!tx_on) begin
      tx_busy_r <= 1'b0;
      tx_cnt_r  <= 4'h0;
    end else if (tx_load) begin
      tsr_r     <= {tx_ninth_bit_r, txbuf_r};
      tx_cnt_r  <= tx9_r ? BITS_9 : BITS_8;
      tx_busy_r <= 1'b1;
    end else if (tx_busy_r && ck_fall) begin
      tsr_r    <= {1'b0, tsr_r[8:1]};
      tx_cnt_r <= tx_cnt_r - 4'h1;
      if (tx_cnt_r == 4'h1) begin
        tx_busy_r <= 1'b0;
      end
    end
  end

  logic data_out_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out_r <= 1'b0;
    end else begin
      data_out_r <= tx_load ? txbuf_r[0] : tsr_r[0];
    end
  end

  assign link_out = '{data_out: data_out_r, data_oe: tx_busy_r & tx_on};

  // -------- receive path --------
  logic [8:0] rsr_r;
  logic [3:0] rx_cnt_r;
  logic [8:0] rsr_nxt;
  logic       rx_done;
  logic [3:0] rx_len;

  // data and ninth bit out of the shifted word, by word length
  function automatic logic [8:0] rx_word(input logic [8:0] sh, input logic nine);
    rx_word = nine ? sh : {1'b0, sh[8:1]};
  endfunction : rx_word

  assign rsr_nxt = {dt_s, rsr_r[8:1]};
  assign rx_len  = rx9_r ? BITS_9 : BITS_8;
  // overrun halts reception until continuous receive is cleared
  assign rx_done = rx_on & ~overrun_error_r & ck_fall & (rx_cnt_r == rx_len - 4'h1);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsr_r    <= 9'h000;
      rx_cnt_r <= 4'h0;
    end else if (!rx_on || overrun_error_r) begin
      rsr_r    <= 9'h000;
      rx_cnt_r <= 4'h0;
    end else if (ck_fall) begin
      rsr_r    <= rsr_nxt;
      rx_cnt_r <= rx_done ? 4'h0 : rx_cnt_r + 4'h1;
    end
  end

  logic [8:0] rx_word_v;
  assign rx_word_v = rx_word(rsr_nxt, rx9_r);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_data_buffer_r <= 8'h00;
      rx_ninth_bit_r  <= 1'b0;
    end else if (rx_done && !receive_flag_r) begin
      rx_data_buffer_r <= rx_word_v[7:0];
      rx_ninth_bit_r  <= rx_word_v[8];
    end
  end

  // error stays until continuous receive is cleared
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      overrun_error_r <= 1'b0;
    end else if (!continuous_receive_enable_r) begin
      overrun_error_r <= 1'b0;
    end else if (rx_done && receive_flag_r) begin
      overrun_error_r <= 1'b1;
    end
  end

  // -------- flags: set beats any clear in the same cycle --------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      transmit_flag_r <= RST_IRQ_FLAGS[IRQ_TRANSMIT];
    end else if (tx_load) begin
      transmit_flag_r <= 1'b1;
    end else if (rd_pir || wr_tx_data_buffer) begin
      transmit_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      receive_flag_r <= RST_IRQ_FLAGS[IRQ_RECEIVE];
    end else if (rx_done) begin
      receive_flag_r <= 1'b1;
    end else if (rd_pir || rd_rx_data_buffer) begin
      receive_flag_r <= 1'b0;
    end
  end

  // -------- interrupt and wake --------
  logic pending;

  assign pending    = (transmit_flag_r & transmit_irq_enable_r) | (receive_flag_r & receive_irq_enable_r);
  // wake ignores the global disable, only vectoring is blocked
  assign wake       = pending;
  assign irq        = pending & ~global_irq_disable_r;
  // vectoring itself clears nothing here; only reads and transmit buffer writes clear flags
  assign irq_vector = VEC_PERIPHERAL;

  // -------- read data, one cycle after the strobe --------
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    case (bus_req.addr)
      ADDR_RX_STATUS_CONTROL: begin
        rd_mux[RX_SERIAL_PORT_ENABLE]    = serial_port_enable_r;
        rd_mux[RX_NINE_BIT_RX_SELECT]    = rx9_r;
        rd_mux[RX_SINGLE_RECEIVE_ENABLE] = single_receive_enable_r;
        rd_mux[RX_CONTINUOUS_RECEIVE_EN] = continuous_receive_enable_r;
        rd_mux[RX_FRAMING_ERROR]         = 1'b0;
        rd_mux[RX_OVERRUN_ERROR]         = overrun_error_r;
        rd_mux[RX_NINTH_BIT]             = rx_ninth_bit_r;
      end
      ADDR_RX_DATA_BUFFER: begin
        rd_mux = rx_data_buffer_r;
      end
      ADDR_TX_STATUS_CONTROL: begin
        rd_mux[TX_CLOCK_SOURCE_SELECT] = clock_source_select_r;
        rd_mux[TX_NINE_BIT_TX_SELECT]  = tx9_r;
        rd_mux[TX_TRANSMIT_ENABLE]     = transmit_enable_r;
        rd_mux[TX_SYNC_MODE]           = sync_r;
        rd_mux[TX_SHIFT_EMPTY]         = ~tx_busy_r;
        rd_mux[TX_NINTH_BIT]           = tx_ninth_bit_r;
      end
      ADDR_BAUD_RATE_DIVISOR: begin
        rd_mux = baud_rate_divisor_r;
      end
      ADDR_CORE_CONTROL: begin
        rd_mux[CORE_GLOBAL_IRQ_DISABLE] = global_irq_disable_r;
      end
      ADDR_PERIPHERAL_IRQ_FLAGS: begin
        rd_mux[IRQ_TRANSMIT] = transmit_flag_r;
        rd_mux[IRQ_RECEIVE]  = receive_flag_r;
      end
      ADDR_PERIPHERAL_IRQ_ENABLES: begin
        rd_mux[IRQ_TRANSMIT] = transmit_irq_enable_r;
        rd_mux[IRQ_RECEIVE]  = receive_irq_enable_r;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= bus_req.rd ? rd_mux : 8'h00;
    end
  end

endmodule : uss_core

`default_nettype wire

//--- uss_core_monitor.sv
// concurrent checks on the ports of the slave serial port core
`timescale 1ns/1ps
`default_nettype none
module uss_core_monitor
  import uss_pkg::*;
(
  // clock and reset
  input wire logic          core_clk,
  input wire logic          arst_n,
  // register port
  input wire uss_bus_req_s  bus_req,
  input wire logic [7:0]    rd_data,
  // link and interrupt
  input wire logic          shift_clk_pin,
  input wire logic          data_pin_in,
  input wire uss_link_out_s link_out,
  input wire logic          irq,
  input wire logic          wake,
  input wire logic [15:0]   irq_vector
);
  logic [1:0] ena_r;
  logic       gdis_r;
  logic       continuous_receive_enable_r;

  // shadows of mask, global disable and receive enable
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ena_r  <= 2'h0;
      gdis_r <= RST_GLOBAL_IRQ_DIS;
      continuous_receive_enable_r <= 1'b0;
    end else if (bus_req.wr) begin
      if (bus_req.addr == ADDR_PERIPHERAL_IRQ_ENABLES) ena_r <= bus_req.wdata[1:0];
      if (bus_req.addr == ADDR_CORE_CONTROL) gdis_r <= bus_req.wdata[0];
      if (bus_req.addr == ADDR_RX_STATUS_CONTROL) continuous_receive_enable_r <= bus_req.wdata[4];
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // a synced shift clock fall lands 3 to 6 cycles after the pin falls
  sequence s_clk_fell_lately;
    !$past(shift_clk_pin, 1) || !$past(shift_clk_pin, 2) || !$past(shift_clk_pin, 3) ||
    !$past(shift_clk_pin, 4) || !$past(shift_clk_pin, 5) || !$past(shift_clk_pin, 6);
  endsequence

  a_vector_fixed: assert property (irq_vector == VEC_PERIPHERAL)
    else $error("vector not at the shared address");
  a_rd_quiet: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
    else $error("read data outside its cycle");
  a_rd_unmapped: assert property (bus_req.rd && bus_req.addr == 7'h1F |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_irq_gated: assert property (irq == (wake && !gdis_r))
    else $error("irq disagrees with wake and global disable");
  a_wake_masked: assert property (wake |-> ena_r != 2'h0)
    else $error("wake with all enables clear");
  a_word_end: assert property ($fell(link_out.data_oe) && !$past(bus_req.wr) &&
    !$past(bus_req.wr, 2) |-> s_clk_fell_lately)
    else $error("drive dropped without a clock fall");
  a_bit_hold: assert property ($changed(link_out.data_out) && link_out.data_oe &&
    $past(link_out.data_oe) |-> s_clk_fell_lately)
    else $error("transmit bit moved without a clock fall");
  a_tx_yields: assert property (continuous_receive_enable_r && $past(continuous_receive_enable_r) |-> !link_out.data_oe)
    else $error("data pin driven while receiving");
endmodule : uss_core_monitor
`default_nettype wire

//--- uss_master_model.sv
// external master: makes the shift clock and shares the data line
`timescale 1ns/1ps
`default_nettype none
module uss_master_model
  import uss_pkg::*;
(
  // from the core
  input wire uss_link_out_s link_out,
  // to the core
  output var logic          shift_clk_pin,
  output var logic          data_pin_in
);
  logic mst_en;
  logic mst_bit;

  initial begin
    shift_clk_pin = 1'b1;
    mst_en = 1'b0;
    mst_bit = 1'b1;
  end

  // line has a pull-up, so an undriven pin reads high
  assign data_pin_in = link_out.data_oe ? link_out.data_out : (mst_en ? mst_bit : 1'b1);

  // clock idles high between frames; bits sampled just before each fall
  task frame(input logic [8:0] tx, input int n, input logic drv, output logic [8:0] rx);
    rx = 9'h000;
    mst_en = drv;
    for (int i = 0; i < n; i++) begin
      #50 mst_bit = tx[i];
      #50 rx[i] = data_pin_in;
      shift_clk_pin = 1'b0;
      #100 shift_clk_pin = 1'b1;
    end
    #50 mst_en = 1'b0;
  endtask : frame
endmodule : uss_master_model
`default_nettype wire

//--- uss_core_tb.sv
// testbench of the slave serial port core
`timescale 1ns/1ps
`default_nettype none
module uss_core_tb;
  import uss_pkg::*;
  logic          core_clk;
  logic          arst_n;
  uss_bus_req_s  bus_req;
  logic [7:0]    rd_data;
  logic          shift_clk_pin;
  logic          data_pin_in;
  uss_link_out_s link_out;
  logic          irq;
  logic          wake;
  logic [15:0]   irq_vector;
  int            mismatches;
  int            n_compared;
  logic [8:0]    got;

  uss_core uss_core_inst (.core_clk(core_clk), .arst_n(arst_n), .bus_req(bus_req),
    .rd_data(rd_data), .shift_clk_pin(shift_clk_pin), .data_pin_in(data_pin_in),
    .link_out(link_out), .irq(irq), .wake(wake), .irq_vector(irq_vector));
  uss_master_model uss_master_model_inst (.link_out(link_out),
    .shift_clk_pin(shift_clk_pin), .data_pin_in(data_pin_in));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task chk(input string nm, input logic [8:0] exp, input logic [8:0] seen);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask : wr

  task rdc(input logic [6:0] a, input logic [7:0] e, input string nm);
    @(posedge core_clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 chk(nm, {1'b0, e}, {1'b0, rd_data});
  endtask : rdc

  // whole frame, then time for the core to finish the word
  task xfer(input logic [8:0] tx, input int n, input logic drv);
    uss_master_model_inst.frame(tx, n, drv, got);
    repeat (12) @(posedge core_clk);
  endtask : xfer

  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  initial begin
    #300000;
    mismatches++;
    stop_test();
  end

  initial begin
    arst_n = 1'b0;
    bus_req = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    rdc(ADDR_PERIPHERAL_IRQ_FLAGS, 8'h02, "flags rst");
    rdc(ADDR_PERIPHERAL_IRQ_ENABLES, 8'h00, "enables rst");
    rdc(ADDR_RX_STATUS_CONTROL, 8'h00, "rx rst");
    rdc(ADDR_TX_STATUS_CONTROL, 8'h02, "tx rst");
    rdc(7'h1F, 8'h00, "unmapped");
    rdc(ADDR_CORE_CONTROL, 8'h01, "core rst");
    // divisor is only stored in slave mode
    wr(ADDR_BAUD_RATE_DIVISOR, 8'h3C);
    rdc(ADDR_BAUD_RATE_DIVISOR, 8'h3C, "divisor");
    // two words queued: first shifts, second waits
    wr(ADDR_TX_STATUS_CONTROL, 8'h10);
    wr(ADDR_RX_STATUS_CONTROL, 8'h80);
    wr(ADDR_PERIPHERAL_IRQ_ENABLES, 8'h02);
    wr(ADDR_TX_DATA_BUFFER, 8'h5A);
    wr(ADDR_TX_STATUS_CONTROL, 8'h30);
    repeat (2) @(posedge core_clk);
    wr(ADDR_TX_DATA_BUFFER, 8'hC3);
    chk("wake", 9'h000, {8'h00, wake});
    chk("drive", 9'h001, {8'h00, link_out.data_oe});
    // buffer already full: this word must be dropped
    wr(ADDR_TX_DATA_BUFFER, 8'hEE);
    rdc(ADDR_PERIPHERAL_IRQ_FLAGS, 8'h00, "flags busy");
    rdc(ADDR_TX_STATUS_CONTROL, 8'h30, "tx busy");
    xfer(9'h000, 8, 1'b0);
    chk("tx word 1", 9'h05A, got);
    chk("wake", 9'h001, {8'h00, wake});
    chk("irq", 9'h000, {8'h00, irq});
    wr(ADDR_CORE_CONTROL, 8'h00);
    repeat (5) @(posedge core_clk);
    chk("irq", 9'h001, {8'h00, irq});
    rdc(ADDR_PERIPHERAL_IRQ_FLAGS, 8'h02, "flags reload");
    chk("irq", 9'h000, {8'h00, irq});
    xfer(9'h000, 8, 1'b0);
    chk("tx word 2", 9'h0C3, got);
    rdc(ADDR_TX_STATUS_CONTROL, 8'h32, "tx idle");
    wr(ADDR_TX_STATUS_CONTROL, 8'h71);
    wr(ADDR_TX_DATA_BUFFER, 8'h81);
    repeat (2) @(posedge core_clk);
    xfer(9'h000, 9, 1'b0);
    chk("tx nine", 9'h181, got);
    // reception, nine bits, overrun and its clearing
    wr(ADDR_TX_STATUS_CONTROL, 8'h10);
    wr(ADDR_PERIPHERAL_IRQ_ENABLES, 8'h01);
    rdc(ADDR_PERIPHERAL_IRQ_FLAGS, 8'h02, "flags masked");
    wr(ADDR_RX_STATUS_CONTROL, 8'h90);
    xfer(9'h0A5, 8, 1'b1);
    chk("irq", 9'h001, {8'h00, irq});
    rdc(ADDR_RX_STATUS_CONTROL, 8'h90, "rx status");
    rdc(ADDR_PERIPHERAL_IRQ_FLAGS, 8'h01, "flags rx");
    rdc(ADDR_RX_DATA_BUFFER, 8'hA5, "rx word");
    wr(ADDR_RX_STATUS_CONTROL, 8'hD0);
    xfer(9'h13C, 9, 1'b1);
    rdc(ADDR_RX_STATUS_CONTROL, 8'hD1, "rx ninth");
    rdc(ADDR_RX_DATA_BUFFER, 8'h3C, "rx nine");
    xfer(9'h011, 9, 1'b1);
    xfer(9'h122, 9, 1'b1);
    rdc(ADDR_RX_STATUS_CONTROL, 8'hD2, "overrun");
    rdc(ADDR_RX_DATA_BUFFER, 8'h11, "kept word");
    wr(ADDR_RX_STATUS_CONTROL, 8'hC0);
    rdc(ADDR_RX_STATUS_CONTROL, 8'hC0, "error gone");
    // single receive enable alone must not receive
    wr(ADDR_RX_STATUS_CONTROL, 8'hA0);
    xfer(9'h0FF, 8, 1'b1);
    rdc(ADDR_PERIPHERAL_IRQ_FLAGS, 8'h00, "single ignored");
    // abort half a word, then receive cleanly
    wr(ADDR_RX_STATUS_CONTROL, 8'h90);
    uss_master_model_inst.frame(9'h0F0, 4, 1'b1, got);
    wr(ADDR_RX_STATUS_CONTROL, 8'h80);
    wr(ADDR_RX_STATUS_CONTROL, 8'h90);
    xfer(9'h066, 8, 1'b1);
    rdc(ADDR_RX_DATA_BUFFER, 8'h66, "after abort");
    stop_test();
  end
endmodule : uss_core_tb

bind uss_core uss_core_monitor uss_core_monitor_inst (.core_clk(core_clk), .arst_n(arst_n),
  .bus_req(bus_req), .rd_data(rd_data), .shift_clk_pin(shift_clk_pin),
  .data_pin_in(data_pin_in), .link_out(link_out), .irq(irq), .wake(wake),
  .irq_vector(irq_vector));
`default_nettype wire
